/* verilog/daa_params.svh */
`ifndef DAA_PARAMS_SVH
`define DAA_PARAMS_SVH

// Clock and timing
`define DAA_CLK_MHZ        100
`define DAA_T_RES_CAL_MS   17
`define DAA_T_ADC_CAL_MS   256
`define DAA_T_LOCK_MS      1
`define DAA_LOCK_EDGES     7'h40
`define DAA_LOSS_W         17
`define DAA_FILT_DELAY     4

// Register byte addresses
`define DAA_ADDR_PWR       8'h00
`define DAA_ADDR_LOOP      8'h04
`define DAA_ADDR_TEST      8'h08
`define DAA_ADDR_LINE      8'h0C
`define DAA_ADDR_CAL       8'h10
`define DAA_ADDR_PCM_LINE_LOOPBACK_ENABLE      8'h14
`define DAA_ADDR_STAT      8'h18

// Field positions
`define DAA_BIT_DATA_LOOP  0
`define DAA_BIT_BARRIER    1
`define DAA_BIT_HYBRID     1
`define DAA_BIT_ANALOG     3
`define DAA_BIT_CHIP_PD    3
`define DAA_BIT_LINE_PD    4
`define DAA_BIT_RESISTOR_CAL_DISABLE      5
`define DAA_BIT_AUTO_CAL_DISABLE       4
`define DAA_BIT_MANUAL_CAL_TRIGGER       3
`define DAA_BIT_PCM_LINE_LOOPBACK_ENABLE       7
`define DAA_BIT_FDT        6
`define DAA_BIT_LOCKED     0
`define DAA_BIT_RES_BUSY   1
`define DAA_BIT_ADC_BUSY   2
`define DAA_BIT_SLEEP      3
`define DAA_BIT_DEEP       4

// Writable masks and reset values
`define DAA_MASK_PWR       8'h18
`define DAA_MASK_LOOP      8'h01
`define DAA_MASK_TEST      8'h02
`define DAA_MASK_LINE      8'h0A
`define DAA_MASK_CAL       8'h38
`define DAA_MASK_PCM_LINE_LOOPBACK_ENABLE      8'h80
`define DAA_RST_PWR        8'h10
`define DAA_RST_LINE       8'h02
`define DAA_RST_ZERO       8'h00

// Synchronised input lanes
`define DAA_NIN            9
`define DAA_IN_PCLK        0
`define DAA_IN_FRAME_SYNC_IN       1
`define DAA_IN_RX          2
`define DAA_IN_LRX         3
`define DAA_IN_LFRM        4
`define DAA_IN_HOOK        5
`define DAA_IN_PLOSS       6
`define DAA_IN_RING        7
`define DAA_IN_DCOK        8

`endif

/* verilog/daa_pkg.sv */
`include "daa_params.svh"

package daa_pkg;

  typedef enum logic [1:0] {
    DAA_MODE_RESET,
    DAA_MODE_NORMAL,
    DAA_MODE_SLEEP,
    DAA_MODE_DEEP
  } daa_pmode_t;

  typedef enum logic [1:0] {
    DAA_CAL_IDLE,
    DAA_CAL_RES,
    DAA_CAL_WAIT_DC,
    DAA_CAL_ADC
  } daa_cal_t;

  typedef struct packed {
    logic [31:0] cnt;
    logic        busy;
    logic        done;
  } daa_tmr_state_t;

  typedef struct packed {
    logic [`DAA_NIN-1:0]        s1;
    logic [`DAA_NIN-1:0]        s2;
    logic [`DAA_NIN-1:0]        s3;
    logic [`DAA_NIN-1:0]        flt;
    logic [7:0]                 pwr;
    logic [7:0]                 loopr;
    logic [7:0]                 test;
    logic [7:0]                 line;
    logic [7:0]                 cal;
    logic [7:0]                 pcm_line_loopback_enable;
    daa_pmode_t                 mode;
    logic [6:0]                 lock_cnt;
    logic                       fs_seen;
    logic                       locked;
    logic [`DAA_LOSS_W-1:0]     idle_cnt;
    daa_cal_t                   cal_st;
    logic                       res_start;
    logic                       adc_start;
    logic [`DAA_FILT_DELAY-1:0] rx_dly;
    logic [`DAA_FILT_DELAY-1:0] lrx_dly;
    logic                       tx;
    logic                       ltx;
    logic [31:0]                prdata;
    logic                       pslverr;
  } daa_state_t;

endpackage

/* verilog/daa_tmr_if.sv */
`timescale 1ns/100ps

interface daa_tmr_if;
  logic start;
  logic busy;
  logic done;

  modport ctrl (output start, input busy, input done);
  modport tmr  (input start, output busy, output done);
endinterface

/* verilog/daa_cal_timer.sv */
`timescale 1ns/100ps

module daa_cal_timer
  import daa_pkg::*;
#(
  parameter logic [31:0] CYCLES = 32'h0000_0010
) (
  input  wire logic clk_i,
  input  wire logic rst_b_i,
  daa_tmr_if.tmr    tmr
);

  daa_tmr_state_t q;
  daa_tmr_state_t next_q;

  always_comb begin
    next_q      = q;
    next_q.done = 1'b0;
    if (q.busy) begin
      if (q.cnt == CYCLES - 32'h1) begin
        next_q.busy = 1'b0;
        next_q.done = 1'b1;
        next_q.cnt  = 32'h0;
      end else begin
        next_q.cnt = q.cnt + 32'h1;
      end
    end else if (tmr.start) begin
      // Start while running is ignored
      next_q.busy = 1'b1;
      next_q.cnt  = 32'h0;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign tmr.busy = q.busy;
  assign tmr.done = q.done;

endmodule

/* verilog/daa_ctrl.sv */
// Behaviour
// R1: After reset the line side stays powered down and never loads the line.
// R2: Host supplies bit clock and frame sync; lock within 1 ms; writing 00H powers line.
// R3: Isolation link off by default; no line traffic until line_side_powerdown clears.
// R4: Host lets the lock complete before clearing line_side_powerdown.
// R5: Reset operation: line_side_powerdown set, chip_powerdown clear, link off, status invalid.
// R6: Both powerdown bits clear gives normal operation with link traffic both ways.
// R7: chip_powerdown alone gives sleep: only link and ring output work; reset exits.
// R8: Host clears line_side_powerdown before sleep and reprograms after the reset.
// R9: Both bits set gives deep powerdown, ring output dead, only reset restores.
// R10: Off-hook or line power loss runs 17 ms resistor calibration unless disabled.
// R11: 256 ms ADC calibration starts after dc termination settles and resistor cal ends.
// R12: Manual ADC calibration on trigger high then low with auto cal disabled; 256 ms.
// R13: Host starts manual calibration about 256 ms before it needs valid data.
// R14: With line_side_powerdown set, receive data loops through filters to transmit.
// R15: Once line_side_powerdown clears, frame detected shows the link is established.
// R16: Data loopback returns receive data unchanged on transmit, bypassing filters.
// R17: Host waits 402.75 ms after going off-hook before selecting line test modes.
// R18: Barrier loopback sends receive data over the link and returns it on transmit.
// R19: Analog loopback makes the line side drive line signals back onto the line.
// R20: PCM line loopback digitises line data, filters it and returns it to the line.
// R21: Clearing hybrid_enable selects internal analog loopback via the line.
// R22: Host enables at most one test mode at a time.
//
// Decided for this implementation: the placing of the registers and the APB interface to the registers.
`timescale 1ns/100ps
`include "daa_params.svh"

module daa_ctrl
  import daa_pkg::*;
#(
  parameter logic [31:0] RES_CAL_CYCLES = 32'(`DAA_T_RES_CAL_MS * 1000 * `DAA_CLK_MHZ),
  parameter logic [31:0] ADC_CAL_CYCLES = 32'(`DAA_T_ADC_CAL_MS * 1000 * `DAA_CLK_MHZ),
  parameter logic [`DAA_LOSS_W-1:0] LOCK_LOSS_CYCLES = `DAA_LOSS_W'(`DAA_T_LOCK_MS * 1000 * `DAA_CLK_MHZ)
) (
  input  wire logic        clk_i,
  input  wire logic        rst_b_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  input  wire logic        pcm_bit_clock_i,
  input  wire logic        frame_sync_in_i,
  input  wire logic        serial_rx_data_i,
  output logic             serial_tx_data_o,
  input  wire logic        link_rx_i,
  input  wire logic        link_frame_ok_i,
  input  wire logic        line_off_hook_i,
  input  wire logic        line_power_lost_i,
  input  wire logic        line_ring_i,
  input  wire logic        dc_term_stable_i,
  output logic             link_tx_o,
  output logic             link_enable_o,
  output logic             barrier_loop_o,
  output logic             analog_loop_o,
  output logic             hybrid_enable_o,
  output logic             ring_detect_out_o,
  output logic             res_cal_busy_o,
  output logic             adc_cal_busy_o
);

  daa_state_t q;
  daa_state_t next_q;

  daa_tmr_if res_if ();
  daa_tmr_if adc_if ();

  daa_cal_timer #(
    .CYCLES (RES_CAL_CYCLES)
  ) u_res_timer (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .tmr     (res_if.tmr)
  );

  daa_cal_timer #(
    .CYCLES (ADC_CAL_CYCLES)
  ) u_adc_timer (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .tmr     (adc_if.tmr)
  );

  logic [`DAA_NIN-1:0] pins;
  logic [`DAA_NIN-1:0] rise;
  logic [`DAA_NIN-1:0] fall;
  logic                link_en;
  logic                link_frame_detected;
  logic                setup;
  logic                wr;
  logic                pd_line;
  logic                pd_chip;
  logic [7:0]          wdat;
  logic [7:0]          stat;
  logic                cal_evt;
  logic                manual;

  assign pins = {dc_term_stable_i, line_ring_i, line_power_lost_i, line_off_hook_i,
                 link_frame_ok_i, link_rx_i, serial_rx_data_i, frame_sync_in_i, pcm_bit_clock_i};

  // Edge once second and third stage agree
  assign rise = (q.s2 ~^ q.s3) & q.s3 & ~q.flt;
  assign fall = (q.s2 ~^ q.s3) & ~q.s3 & q.flt;

  assign link_en = (q.mode == DAA_MODE_NORMAL) || (q.mode == DAA_MODE_SLEEP);  // see R3
  assign link_frame_detected     = link_en & q.flt[`DAA_IN_LFRM];  // see R15
  assign setup   = psel_i & ~penable_i;
  assign wr      = psel_i & penable_i & pwrite_i;
  assign wdat    = pwdata_i[7:0];

  assign stat = {1'b0, link_frame_detected, 1'b0,
                 q.mode == DAA_MODE_DEEP, q.mode == DAA_MODE_SLEEP,
                 adc_if.busy, res_if.busy, q.locked};

  // Line events only reach us while the link runs
  assign cal_evt = link_en & (rise[`DAA_IN_HOOK] | rise[`DAA_IN_PLOSS]);  // see R10

  // Trigger taken high then back low, only with auto cal disabled
  assign manual = wr && (paddr_i == `DAA_ADDR_CAL) && q.cal[`DAA_BIT_MANUAL_CAL_TRIGGER]
                  && !wdat[`DAA_BIT_MANUAL_CAL_TRIGGER] && q.cal[`DAA_BIT_AUTO_CAL_DISABLE];  // see R12

  always_comb begin
    next_q           = q;
    pd_line          = q.pwr[`DAA_BIT_LINE_PD];
    pd_chip          = q.pwr[`DAA_BIT_CHIP_PD];
    next_q.res_start = 1'b0;
    next_q.adc_start = 1'b0;

    // Pin synchronisers
    next_q.s1 = pins;
    next_q.s2 = q.s1;
    next_q.s3 = q.s2;
    for (int i = 0; i < `DAA_NIN; i++) begin
      if (q.s2[i] == q.s3[i]) begin
        next_q.flt[i] = q.s3[i];
      end
    end

    // Lock to bit clock once frame sync has been seen
    if (rise[`DAA_IN_FRAME_SYNC_IN]) begin
      next_q.fs_seen = 1'b1;
    end
    if (rise[`DAA_IN_PCLK]) begin
      next_q.idle_cnt = '0;
      if (q.fs_seen) begin
        if (q.lock_cnt == `DAA_LOCK_EDGES) begin
          next_q.locked = 1'b1;  // see R2
        end else begin
          next_q.lock_cnt = q.lock_cnt + 7'h1;
        end
      end
    end else if (q.idle_cnt == LOCK_LOSS_CYCLES) begin
      next_q.locked   = 1'b0;
      next_q.lock_cnt = '0;
      next_q.fs_seen  = 1'b0;
    end else begin
      next_q.idle_cnt = q.idle_cnt + `DAA_LOSS_W'(1);
    end

    // Register writes in the access phase
    if (wr) begin
      case (paddr_i)
        `DAA_ADDR_PWR: begin
          // Sleep and deep powerdown are left only by reset
          if (q.mode != DAA_MODE_SLEEP && q.mode != DAA_MODE_DEEP) begin  // see R7 see R9
            next_q.pwr = wdat & `DAA_MASK_PWR;
          end
        end
        `DAA_ADDR_LOOP: next_q.loopr = wdat & `DAA_MASK_LOOP;
        `DAA_ADDR_TEST: next_q.test  = wdat & `DAA_MASK_TEST;
        `DAA_ADDR_LINE: next_q.line  = wdat & `DAA_MASK_LINE;
        `DAA_ADDR_CAL:  next_q.cal   = wdat & `DAA_MASK_CAL;
        `DAA_ADDR_PCM_LINE_LOOPBACK_ENABLE: next_q.pcm_line_loopback_enable  = wdat & `DAA_MASK_PCM_LINE_LOOPBACK_ENABLE;
        default: begin
        end
      endcase
    end

    // Power mode from the two powerdown bits
    pd_line = next_q.pwr[`DAA_BIT_LINE_PD];
    pd_chip = next_q.pwr[`DAA_BIT_CHIP_PD];
    if (q.mode != DAA_MODE_SLEEP && q.mode != DAA_MODE_DEEP) begin
      if (pd_chip && pd_line) begin
        next_q.mode = DAA_MODE_DEEP;  // see R9
      end else if (pd_chip) begin
        next_q.mode = DAA_MODE_SLEEP;  // see R7
      end else if (pd_line) begin
        next_q.mode = DAA_MODE_RESET;  // see R5
      end else begin
        next_q.mode = DAA_MODE_NORMAL;  // see R6
      end
    end

    // Calibration sequencing
    case (q.cal_st)
      DAA_CAL_IDLE: begin
        if (cal_evt) begin
          if (!q.cal[`DAA_BIT_RESISTOR_CAL_DISABLE]) begin
            next_q.res_start = 1'b1;  // see R10
            next_q.cal_st    = DAA_CAL_RES;
          end else begin
            next_q.cal_st = DAA_CAL_WAIT_DC;
          end
        end else if (manual) begin
          next_q.adc_start = 1'b1;  // see R12
          next_q.cal_st    = DAA_CAL_ADC;
        end
      end
      DAA_CAL_RES: begin
        if (res_if.done) begin
          next_q.cal_st = DAA_CAL_WAIT_DC;
        end
      end
      DAA_CAL_WAIT_DC: begin
        if (q.flt[`DAA_IN_DCOK]) begin
          if (!q.cal[`DAA_BIT_AUTO_CAL_DISABLE]) begin
            next_q.adc_start = 1'b1;  // see R11
            next_q.cal_st    = DAA_CAL_ADC;
          end else begin
            next_q.cal_st = DAA_CAL_IDLE;
          end
        end
      end
      DAA_CAL_ADC: begin
        if (adc_if.done) begin
          next_q.cal_st = DAA_CAL_IDLE;
        end
      end
      default: next_q.cal_st = DAA_CAL_IDLE;
    endcase

    // Serial data path, one bit per bit-clock rising edge
    if (rise[`DAA_IN_PCLK]) begin
      next_q.rx_dly  = {q.rx_dly[`DAA_FILT_DELAY-2:0], q.flt[`DAA_IN_RX]};
      next_q.lrx_dly = {q.lrx_dly[`DAA_FILT_DELAY-2:0], q.flt[`DAA_IN_LRX]};
      if (q.mode == DAA_MODE_SLEEP || q.mode == DAA_MODE_DEEP) begin
        next_q.tx = 1'b0;  // see R7
      end else if (q.loopr[`DAA_BIT_DATA_LOOP]) begin
        next_q.tx = q.flt[`DAA_IN_RX];  // see R16
      end else if (q.mode == DAA_MODE_RESET) begin
        next_q.tx = q.rx_dly[`DAA_FILT_DELAY-1];  // see R14
      end else begin
        // Return from line side: normal, barrier and internal analog paths
        next_q.tx = q.lrx_dly[`DAA_FILT_DELAY-1];  // see R6 see R18 see R21
      end
      if (!link_en) begin
        next_q.ltx = 1'b0;  // see R3
      end else if (q.pcm_line_loopback_enable[`DAA_BIT_PCM_LINE_LOOPBACK_ENABLE]) begin
        next_q.ltx = q.lrx_dly[`DAA_FILT_DELAY-1];  // see R20
      end else begin
        next_q.ltx = q.rx_dly[`DAA_FILT_DELAY-1];  // see R18
      end
    end

    // APB read data captured in the setup phase
    if (setup) begin
      next_q.pslverr = 1'b0;
      case (paddr_i)
        `DAA_ADDR_PWR:  next_q.prdata = {24'h0, q.pwr};
        `DAA_ADDR_LOOP: next_q.prdata = {24'h0, q.loopr};
        `DAA_ADDR_TEST: next_q.prdata = {24'h0, q.test};
        `DAA_ADDR_LINE: next_q.prdata = {24'h0, q.line};
        `DAA_ADDR_CAL:  next_q.prdata = {24'h0, q.cal};
        `DAA_ADDR_PCM_LINE_LOOPBACK_ENABLE: next_q.prdata = {24'h0, q.pcm_line_loopback_enable};
        `DAA_ADDR_STAT: next_q.prdata = {24'h0, stat};
        default: begin
          next_q.prdata  = 32'h0;
          next_q.pslverr = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      q          <= '0;
      q.pwr      <= `DAA_RST_PWR;  // see R1 see R5
      q.line     <= `DAA_RST_LINE;
      q.loopr    <= `DAA_RST_ZERO;
      q.mode     <= DAA_MODE_RESET;
      q.cal_st   <= DAA_CAL_IDLE;
    end else begin
      q <= next_q;
    end
  end

  assign res_if.start = q.res_start;
  assign adc_if.start = q.adc_start;

  assign prdata_o          = q.prdata;
  assign pready_o          = penable_i;
  assign pslverr_o         = psel_i & penable_i & q.pslverr;
  assign serial_tx_data_o  = q.tx;
  assign link_tx_o         = q.ltx;
  assign link_enable_o     = link_en;  // see R3
  assign barrier_loop_o    = link_en & q.test[`DAA_BIT_BARRIER];  // see R18
  assign analog_loop_o     = link_en & (q.line[`DAA_BIT_ANALOG] | q.pcm_line_loopback_enable[`DAA_BIT_PCM_LINE_LOOPBACK_ENABLE]);  // see R19 see R20
  assign hybrid_enable_o   = q.line[`DAA_BIT_HYBRID];  // see R21
  assign ring_detect_out_o = link_en & q.flt[`DAA_IN_RING];  // see R7 see R9
  assign res_cal_busy_o    = res_if.busy;
  assign adc_cal_busy_o    = adc_if.busy;

endmodule

/* dv/daa_ctrl_sva.sv */
`timescale 1ns/100ps
`include "daa_params.svh"
module daa_ctrl_sva
  import daa_pkg::*;
#(
  parameter logic [31:0] RES_CAL_CYCLES = 32'h64
) (
  input wire logic        clk_i,
  input wire logic        rst_b_i,
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [7:0]  paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic        pready_o,
  input wire logic        pslverr_o,
  input wire logic        link_enable_o,
  input wire logic        barrier_loop_o,
  input wire logic        hybrid_enable_o,
  input wire logic        ring_detect_out_o,
  input wire logic        res_cal_busy_o,
  input wire logic        adc_cal_busy_o
);
  logic [31:0] run;
  logic        acc;
  assign acc = psel_i && penable_i;
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      run <= 32'h0;
    end else begin
      run <= res_cal_busy_o ? run + 32'h1 : 32'h0;
    end
  end
  default clocking dck @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  property p_rdy; acc |-> pready_o; endproperty
  property p_err; pslverr_o |-> acc; endproperty
  property p_unmap; acc && paddr_i > `DAA_ADDR_STAT |-> pslverr_o; endproperty
  property p_rst; $rose(rst_b_i) |-> (!link_enable_o && hybrid_enable_o)[*2]; endproperty
  property p_ring; ring_detect_out_o |-> link_enable_o || $past(link_enable_o); endproperty
  property p_excl; $rose(adc_cal_busy_o) |-> !res_cal_busy_o && !$past(res_cal_busy_o); endproperty
  property p_len; $fell(res_cal_busy_o) |-> run == RES_CAL_CYCLES; endproperty
  property p_hyb; acc && pwrite_i && paddr_i == `DAA_ADDR_LINE |=> hybrid_enable_o == $past(pwdata_i[1]); endproperty
  property p_bar;
    acc && pwrite_i && paddr_i == `DAA_ADDR_TEST |=> barrier_loop_o == ($past(pwdata_i[1]) && link_enable_o);
  endproperty
  a_rdy: assert property (p_rdy) else $error("no ready in access");
  a_err: assert property (p_err) else $error("error outside access");
  a_unmap: assert property (p_unmap) else $error("unmapped not refused");
  a_rst: assert property (p_rst) else $error("unsafe after reset");
  a_ring: assert property (p_ring) else $error("ring out with link off");
  a_excl: assert property (p_excl) else $error("adc cal overlaps res cal");
  a_len: assert property (p_len) else $error("res cal length wrong");
  a_hyb: assert property (p_hyb) else $error("hybrid not written");
  a_bar: assert property (p_bar) else $error("barrier loop not written");
  c_res: cover property ($fell(res_cal_busy_o));
  c_adc: cover property ($rose(adc_cal_busy_o));
  c_ring: cover property (ring_detect_out_o);
endmodule

bind daa_ctrl daa_ctrl_sva #(.RES_CAL_CYCLES(RES_CAL_CYCLES)) daa_ctrl_sva_inst (.clk_i, .rst_b_i, .psel_i,
  .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .pready_o, .pslverr_o, .link_enable_o, .barrier_loop_o,
  .hybrid_enable_o, .ring_detect_out_o, .res_cal_busy_o, .adc_cal_busy_o);

/* dv/daa_pcm_host.sv */
`timescale 1ns/100ps
module daa_pcm_host #(
  parameter int HALF_NS = 80
) (
  output logic pcm_bit_clock_o,
  output logic frame_sync_o,
  output logic serial_rx_data_o
);
  localparam logic [15:0] PAT = 16'hB38E;
  int n;
  initial begin
    n = 0;
    pcm_bit_clock_o = 1'b0;
    frame_sync_o = 1'b0;
    serial_rx_data_o = 1'b0;
    #3;
    // Free running bit clock and frame sync, kept alive in sleep
    forever begin
      #(HALF_NS);
      pcm_bit_clock_o = 1'b1;
      #(HALF_NS);
      pcm_bit_clock_o = 1'b0;
      n++;
      frame_sync_o = (n % 8 == 0);
      serial_rx_data_o = PAT[n % 16];
    end
  end
endmodule

/* dv/daa_power_cal_loopback_ctrl_bench.sv */
`timescale 1ns/100ps
`include "daa_params.svh"
module daa_power_cal_loopback_ctrl_bench;
  localparam int RES_N = 100;
  localparam int ADC_N = 200;
  logic        clk_i, rst_b_i, psel_i, penable_i, pwrite_i, pcm_bit_clock_i, frame_sync_in_i, er;
  logic        serial_rx_data_i, serial_tx_data_o, link_rx_i, link_frame_ok_i, line_off_hook_i;
  logic        line_power_lost_i, line_ring_i, dc_term_stable_i, link_tx_o, link_enable_o;
  logic        barrier_loop_o, analog_loop_o, hybrid_enable_o, ring_detect_out_o, res_cal_busy_o;
  logic        adc_cal_busy_o, pready_o, pslverr_o;
  logic [2:0]  mode_out;
  logic [7:0]  paddr_i;
  logic [31:0] pwdata_i, prdata_o, rd;
  int          err_total, compares, len;
  assign mode_out = {barrier_loop_o, analog_loop_o, hybrid_enable_o};

  daa_ctrl #(
    .RES_CAL_CYCLES  (32'(RES_N)),
    .ADC_CAL_CYCLES  (32'(ADC_N)),
    .LOCK_LOSS_CYCLES(17'h001F4)
  ) daa_ctrl_inst (
    .clk_i, .rst_b_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o,
    .pcm_bit_clock_i, .frame_sync_in_i, .serial_rx_data_i, .serial_tx_data_o, .link_rx_i, .link_frame_ok_i,
    .line_off_hook_i, .line_power_lost_i, .line_ring_i, .dc_term_stable_i, .link_tx_o, .link_enable_o,
    .barrier_loop_o, .analog_loop_o, .hybrid_enable_o, .ring_detect_out_o, .res_cal_busy_o, .adc_cal_busy_o
  );
  daa_pcm_host daa_pcm_host_inst (
    .pcm_bit_clock_o (pcm_bit_clock_i),
    .frame_sync_o    (frame_sync_in_i),
    .serial_rx_data_o(serial_rx_data_i)
  );
  always #5 clk_i = ~clk_i;

  task finish_test;
    if (err_total == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task timeout;
    chk("wait", 32'h1, 32'h0);
    finish_test();
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 16);
    if (pready_o !== 1'b1) timeout();
    rd = prdata_o;
    er = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  function automatic logic sig(input int s);
    case (s)
      0: return res_cal_busy_o;
      1: return adc_cal_busy_o;
      default: return ring_detect_out_o;
    endcase
  endfunction
  task wait_hi(input int s, input int lim);
    int n;
    n = 0;
    while (sig(s) !== 1'b1 && n < lim) begin
      @(posedge clk_i);
      n++;
    end
    if (sig(s) !== 1'b1) timeout();
  endtask
  task busy_len(input int s);
    len = 0;
    while (sig(s) === 1'b1 && len < 1000) begin
      @(posedge clk_i);
      len++;
    end
  endtask
  // Transmit bit must equal receive bit d edges back (filter delay may count one less)
  task check_path(input logic sel, input int d);
    logic h[$];
    int   m0, m1;
    m0 = 0;
    m1 = 0;
    h.delete();
    repeat (32) begin
      @(posedge pcm_bit_clock_i);
      if (h.size() > d && (sel ? link_tx_o : serial_tx_data_o) !== h[d]) m0++;
      if (h.size() > d && (sel ? link_tx_o : serial_tx_data_o) !== h[(d > 0) ? d - 1 : 0]) m1++;
      h.push_front(serial_rx_data_i);
    end
    chk("path errors", 32'h0, (m0 != 0 && m1 != 0) ? 32'(m0) : 32'h0);
  endtask
  task rst_pulse;
    @(posedge clk_i);
    rst_b_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    rst_b_i <= 1'b1;
  endtask

  task t_defaults;
    logic [7:0] ex [6];
    ex = '{8'h10, 8'h00, 8'h00, 8'h02, 8'h00, 8'h00};
    for (int i = 0; i < 6; i++) begin
      apb(1'b0, 8'(4 * i), 32'h0);
      chk("reset value", 32'(ex[i]), rd);
    end
    apb(1'b0, 8'h40, 32'h0);
    chk("unmapped", 32'h1, {rd[30:0], er});
    line_ring_i <= 1'b1;
    repeat (12) @(posedge clk_i);
    chk("link idle", 32'h0, {link_enable_o, link_tx_o, ring_detect_out_o});
    apb(1'b0, `DAA_ADDR_STAT, 32'h0);
    chk("frame det off", 32'h0, {31'h0, rd[6]});
    check_path(1'b0, `DAA_FILT_DELAY);
    apb(1'b1, `DAA_ADDR_LOOP, 32'h01);
    check_path(1'b0, 0);
    apb(1'b1, `DAA_ADDR_LOOP, 32'h00);
  endtask
  task t_normal;
    int n;
    n = 0;
    rd = 32'h0;
    while (rd[0] !== 1'b1 && n < 800) begin
      apb(1'b0, `DAA_ADDR_STAT, 32'h0);
      n++;
    end
    if (rd[0] !== 1'b1) timeout();
    apb(1'b1, `DAA_ADDR_PWR, 32'h00);
    repeat (40) @(posedge clk_i);
    apb(1'b0, `DAA_ADDR_STAT, 32'h0);
    chk("frame det on", 32'h3, {rd[6], link_enable_o});
    check_path(1'b1, `DAA_FILT_DELAY);
    chk("tx from line", 32'h0, {31'h0, serial_tx_data_o});
    link_rx_i <= 1'b1;
    repeat (120) @(posedge clk_i);
    chk("tx follows line", 32'h1, {31'h0, serial_tx_data_o});
  endtask
  task t_cal;
    dc_term_stable_i <= 1'b0;
    line_off_hook_i <= 1'b1;
    wait_hi(0, 12);
    busy_len(0);
    chk("res cal len", 32'(RES_N), 32'(len));
    repeat (20) @(posedge clk_i);
    chk("adc waits dc", 32'h0, {31'h0, adc_cal_busy_o});
    dc_term_stable_i <= 1'b1;
    wait_hi(1, 12);
    busy_len(1);
    chk("adc cal len", 32'(ADC_N), 32'(len));
    apb(1'b1, `DAA_ADDR_CAL, 32'h20);
    line_power_lost_i <= 1'b1;
    wait_hi(1, 20);
    busy_len(1);
    apb(1'b1, `DAA_ADDR_CAL, 32'h30);
    apb(1'b1, `DAA_ADDR_CAL, 32'h38);
    apb(1'b1, `DAA_ADDR_CAL, 32'h30);
    wait_hi(1, 12);
    busy_len(1);
    chk("manual cal len", 32'(ADC_N), 32'(len));
  endtask
  task t_modes;
    logic [7:0] ma [4];
    logic [7:0] mv [4];
    logic [2:0] me [4];
    logic [7:0] mr [4];
    ma = '{`DAA_ADDR_TEST, `DAA_ADDR_LINE, `DAA_ADDR_PCM_LINE_LOOPBACK_ENABLE, `DAA_ADDR_LINE};
    mv = '{8'h02, 8'h0A, 8'h80, 8'h00};
    me = '{3'b101, 3'b011, 3'b011, 3'b000};
    mr = '{8'h00, 8'h02, 8'h00, 8'h02};
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, ma[i], 32'(mv[i]));
      apb(1'b0, ma[i], 32'h0);
      chk("mode readback", 32'(mv[i]), rd);
      chk("mode outputs", 32'(me[i]), 32'(mode_out));
      apb(1'b1, ma[i], 32'(mr[i]));
    end
  endtask
  task t_power;
    apb(1'b1, `DAA_ADDR_PWR, 32'h08);
    wait_hi(2, 12);
    apb(1'b1, `DAA_ADDR_PWR, 32'h00);
    apb(1'b0, `DAA_ADDR_STAT, 32'h0);
    chk("sleep", 32'h3, {rd[3], link_enable_o});
    rst_pulse();
    apb(1'b0, `DAA_ADDR_PWR, 32'h0);
    chk("pwr after wake", 32'h10, rd);
    apb(1'b1, `DAA_ADDR_PWR, 32'h18);
    apb(1'b1, `DAA_ADDR_PWR, 32'h00);
    repeat (12) @(posedge clk_i);
    apb(1'b0, `DAA_ADDR_STAT, 32'h0);
    chk("deep", 32'h4, {rd[4], link_enable_o, ring_detect_out_o});
    rst_pulse();
  endtask

  initial begin
    clk_i = 1'b0;
    rst_b_i = 1'b0;
    {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} = '0;
    {link_rx_i, line_off_hook_i, line_power_lost_i, line_ring_i, dc_term_stable_i} = '0;
    link_frame_ok_i = 1'b1;
    err_total = 0;
    compares = 0;
    repeat (2) @(posedge clk_i);
    rst_b_i <= 1'b1;
    t_defaults();
    t_normal();
    t_cal();
    t_modes();
    t_power();
    finish_test();
  end
endmodule
